// ==== dsdlp_top.sv ====
`timescale 1ns/1ps
// Dual serial DAC load port: two independent framed serial inputs, each
// with an input latch, a DAC latch and an active-low load strobe
module dsdlp_top (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        SHIFT_CLOCK_CH0,
	input  wire logic        FRAME_SYNC_CH0_B,
	input  wire logic        SERIAL_IN_CH0,
	input  wire logic        LOAD_STROBE_CH0_B,
	input  wire logic        SHIFT_CLOCK_CH1,
	input  wire logic        FRAME_SYNC_CH1_B,
	input  wire logic        SERIAL_IN_CH1,
	input  wire logic        LOAD_STROBE_CH1_B,
	output logic signed [15:0] DAC_CODE_CH0,
	output logic signed [15:0] DAC_CODE_CH1,
	output logic             DAC_UPDATE_CH0,
	output logic             DAC_UPDATE_CH1
);
	localparam int N = dsdlp_pkg::NUM_CH;
	localparam int W = dsdlp_pkg::WORD_BITS;

	wire [N-1:0]  shift_clock;
	wire [N-1:0]  frame_sync;
	wire [N-1:0]  serial_in;
	wire [N-1:0]  load_strobe;
	wire [W-1:0]  link_latch [N];
	wire [N-1:0]  link_toggle;
	logic [W-1:0] dac_latch [N];
	logic [N-1:0] dac_update;

	// Gather the per channel pins so one loop serves both channels
	assign shift_clock = {SHIFT_CLOCK_CH1, SHIFT_CLOCK_CH0};
	assign frame_sync  = {FRAME_SYNC_CH1_B, FRAME_SYNC_CH0_B};
	assign serial_in   = {SERIAL_IN_CH1, SERIAL_IN_CH0};
	assign load_strobe = {LOAD_STROBE_CH1_B, LOAD_STROBE_CH0_B};

	generate
		for (genvar ch = 0; ch < N; ch++) begin : g_ch
			logic [W-1:0] input_copy;
			logic         strobe_meta;
			logic         strobe_sync;
			logic         strobe_prev;
			logic         toggle_meta;
			logic         toggle_sync;
			logic         toggle_seen;
			wire          new_word;
			wire          strobe_fall;
			wire          auto_load;
			wire          load_now;
			wire  [W-1:0] next_dac;

			// Each channel has its own link clock domain and port
			dsdlp_shift_port u_port (
				.shift_clock (shift_clock[ch]),
				.rst_b       (RST_B),
				.frame_sync  (frame_sync[ch]),
				.serial_in   (serial_in[ch]),
				.input_latch (link_latch[ch]),
				.word_toggle (link_toggle[ch])
			);

			// Strobe pin and word toggle cross in through two flops each
			always_ff @(posedge MCLK or negedge RST_B) begin
				if (!RST_B) begin
					strobe_meta <= 1'b1;
					strobe_sync <= 1'b1;
					strobe_prev <= 1'b1;
					toggle_meta <= 1'b0;
					toggle_sync <= 1'b0;
					toggle_seen <= 1'b0;
				end else begin
					strobe_meta <= load_strobe[ch];
					strobe_sync <= strobe_meta;
					strobe_prev <= strobe_sync;
					toggle_meta <= link_toggle[ch];
					toggle_sync <= toggle_meta;
					toggle_seen <= toggle_sync;
				end
			end

			// The link latch holds still for fifteen more shift clocks after
			// its toggle, far longer than the two flop crossing needs
			assign new_word    = toggle_sync ^ toggle_seen;
			assign strobe_fall = strobe_prev & ~strobe_sync;
			assign auto_load   = new_word & ~strobe_sync;
			assign load_now    = auto_load | strobe_fall;
			// A word arriving under a low strobe is the newest one to copy
			assign next_dac    = auto_load ? link_latch[ch] : input_copy;

			// Input latch copy on the system side
			always_ff @(posedge MCLK or negedge RST_B) begin
				if (!RST_B)
					input_copy <= dsdlp_pkg::WORD_RESET;
				else if (new_word)
					input_copy <= link_latch[ch];
			end

			// DAC latch changes only on a load, never on a bare write
			always_ff @(posedge MCLK or negedge RST_B) begin
				if (!RST_B) begin
					dac_latch[ch]  <= dsdlp_pkg::WORD_RESET;
					dac_update[ch] <= 1'b0;
				end else begin
					dac_update[ch] <= load_now;
					if (load_now)
						dac_latch[ch] <= next_dac;
				end
			end
		end
	endgenerate

	// Codes leave as signed two's complement words
	assign DAC_CODE_CH0   = $signed(dac_latch[0]);
	assign DAC_CODE_CH1   = $signed(dac_latch[1]);
	assign DAC_UPDATE_CH0 = dac_update[0];
	assign DAC_UPDATE_CH1 = dac_update[1];
endmodule : dsdlp_top

// ==== dsdlp_shift_port.sv ====
// What this block does
// - A falling load strobe copies the channel input latch into its DAC latch.
// - Strobe held low: copy happens on the sixteenth falling shift clock edge.
// - Host drops frame sync to open a word; device starts a frame there.
// - Serial data is sampled on falling shift clock edges while frame sync is low.
// - Shifted bits build the input latch only, never the DAC latch directly.
// - Second channel is an identical, fully independent copy of the first.
// - Second channel auto copy counts edges of its own shift clock.
// - Each frame carries sixteen data bits on sixteen falling edges.
// - The converter code comes only from the DAC latch.
// - The DAC latch word is a two's complement signed code.
package dsdlp_pkg;
	localparam int          NUM_CH     = 2;
	localparam int          WORD_BITS  = 16;
	localparam int          CNT_W      = 5;
	localparam logic [4:0]  CNT_ZERO   = 5'h00;
	localparam logic [4:0]  CNT_ONE    = 5'h01;
	localparam logic [4:0]  CNT_LAST   = 5'h0F;
	localparam logic [4:0]  CNT_FULL   = 5'h10;
	localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : dsdlp_pkg

`timescale 1ns/1ps
// Link side of one channel, clocked on the falling edge of its shift clock
module dsdlp_shift_port (
	input  wire logic                               shift_clock,
	input  wire logic                               rst_b,
	input  wire logic                               frame_sync,
	input  wire logic                               serial_in,
	output logic [dsdlp_pkg::WORD_BITS-1:0]         input_latch,
	output logic                                    word_toggle
);
	logic [dsdlp_pkg::CNT_W-1:0]     bit_count;
	logic [dsdlp_pkg::WORD_BITS-1:0] shift_reg;
	wire                             taking;
	wire                             last_bit;
	wire [dsdlp_pkg::WORD_BITS-1:0]  full_word;

	// Bits are taken only inside a frame and before the word is full
	assign taking    = !frame_sync && (bit_count != dsdlp_pkg::CNT_FULL);
	assign last_bit  = taking && (bit_count == dsdlp_pkg::CNT_LAST);
	assign full_word = {shift_reg[dsdlp_pkg::WORD_BITS-2:0], serial_in};

	// Frame sync high clears the count without a clock edge, since the
	// shift clock may stand still between frames
	always_ff @(negedge shift_clock or negedge rst_b or posedge frame_sync) begin
		if (!rst_b)
			bit_count <= dsdlp_pkg::CNT_ZERO;
		else if (frame_sync)
			bit_count <= dsdlp_pkg::CNT_ZERO;
		else if (taking)
			bit_count <= bit_count + dsdlp_pkg::CNT_ONE;
	end

	// MSB first shift of sampled data
	always_ff @(negedge shift_clock or negedge rst_b) begin
		if (!rst_b)
			shift_reg <= dsdlp_pkg::WORD_RESET;
		else if (taking)
			shift_reg <= full_word;
	end

	// Sixteenth edge loads the input latch and flags the new word
	always_ff @(negedge shift_clock or negedge rst_b) begin
		if (!rst_b) begin
			input_latch <= dsdlp_pkg::WORD_RESET;
			word_toggle <= 1'b0;
		end else if (last_bit) begin
			input_latch <= full_word;
			word_toggle <= ~word_toggle;
		end
	end
endmodule : dsdlp_shift_port

// ==== dsdlp_host_model.sv ====
`timescale 1ns/1ps
// Host serial transmit port; clock idles high and runs only inside frames
module dsdlp_host_model (
	output logic sclk,
	output logic fs_b,
	output logic sd
);
	initial begin
		sclk = 1'b1;
		fs_b = 1'b1;
		sd = 1'b0;
	end
	// Data moves on rising edges so it is stable at each falling edge
	task automatic send(input logic [15:0] w, input int n);
		fs_b = 1'b0;
		#2;
		for (int i = 0; i < n; i++) begin
			sd = w[15 - (i % 16)];
			#3 sclk = 1'b0;
			#3 sclk = 1'b1;
		end
		#2 fs_b = 1'b1;
		sd = ~sd; // Released line must not echo the last bit
	endtask : send
endmodule : dsdlp_host_model

// ==== dsdlp_top_sva.sv ====
`timescale 1ns/1ps
module dsdlp_top_chk (
	input wire logic               MCLK,
	input wire logic               RST_B,
	input wire logic               LOAD_STROBE_CH0_B,
	input wire logic               LOAD_STROBE_CH1_B,
	input wire logic signed [15:0] DAC_CODE_CH0,
	input wire logic signed [15:0] DAC_CODE_CH1,
	input wire logic               DAC_UPDATE_CH0,
	input wire logic               DAC_UPDATE_CH1
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// Update marks last one cycle, and every code change comes with an update mark
	property p_pw0; DAC_UPDATE_CH0 |=> !DAC_UPDATE_CH0; endproperty
	a_pw0: assert property (p_pw0) else $error("pw0");
	property p_pw1; DAC_UPDATE_CH1 |=> !DAC_UPDATE_CH1; endproperty
	a_pw1: assert property (p_pw1) else $error("pw1");
	property p_cg0; $changed(DAC_CODE_CH0) |-> DAC_UPDATE_CH0; endproperty
	a_cg0: assert property (p_cg0) else $error("cg0");
	property p_cg1; $changed(DAC_CODE_CH1) |-> DAC_UPDATE_CH1; endproperty
	a_cg1: assert property (p_cg1) else $error("cg1");
	property p_ld0; $fell(LOAD_STROBE_CH0_B) |-> ##[1:4] DAC_UPDATE_CH0;
	endproperty
	a_ld0: assert property (p_ld0) else $error("ld0");
	property p_ld1; $fell(LOAD_STROBE_CH1_B) |-> ##[1:4] DAC_UPDATE_CH1;
	endproperty
	a_ld1: assert property (p_ld1) else $error("ld1");
	// Loads need the strobe low, whether pulsed or tied
	property p_cs0; DAC_UPDATE_CH0 |-> !$past(LOAD_STROBE_CH0_B, 2);
	endproperty
	a_cs0: assert property (p_cs0) else $error("cs0");
	property p_cs1; DAC_UPDATE_CH1 |-> !$past(LOAD_STROBE_CH1_B, 2);
	endproperty
	a_cs1: assert property (p_cs1) else $error("cs1");
endmodule : dsdlp_top_chk
bind dsdlp_top dsdlp_top_chk u_chk (.MCLK(MCLK), .RST_B(RST_B),
	.LOAD_STROBE_CH0_B(LOAD_STROBE_CH0_B),
	.LOAD_STROBE_CH1_B(LOAD_STROBE_CH1_B),
	.DAC_CODE_CH0(DAC_CODE_CH0), .DAC_CODE_CH1(DAC_CODE_CH1),
	.DAC_UPDATE_CH0(DAC_UPDATE_CH0), .DAC_UPDATE_CH1(DAC_UPDATE_CH1));

// ==== dsdlp_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module dsdlp_top_tb;
	logic              mclk = 1'b0;
	logic              rst_b = 1'b0;
	logic              ld0_b = 1'b1;
	logic              ld1_b = 1'b1;
	wire               sc0, fs0_b, sd0, sc1, fs1_b, sd1, upd0, upd1;
	wire signed [15:0] code0, code1;
	int                bad_count = 0;
	int                n_tests = 0;
	// System clock
	initial forever #5 mclk = ~mclk;
	dsdlp_host_model u_h0 (.sclk(sc0), .fs_b(fs0_b), .sd(sd0));
	dsdlp_host_model u_h1 (.sclk(sc1), .fs_b(fs1_b), .sd(sd1));
	dsdlp_top u_dut (.MCLK(mclk), .RST_B(rst_b), .SHIFT_CLOCK_CH0(sc0),
		.FRAME_SYNC_CH0_B(fs0_b), .SERIAL_IN_CH0(sd0),
		.LOAD_STROBE_CH0_B(ld0_b), .SHIFT_CLOCK_CH1(sc1),
		.FRAME_SYNC_CH1_B(fs1_b), .SERIAL_IN_CH1(sd1),
		.LOAD_STROBE_CH1_B(ld1_b), .DAC_CODE_CH0(code0),
		.DAC_CODE_CH1(code1), .DAC_UPDATE_CH0(upd0), .DAC_UPDATE_CH1(upd1));
	// Fixed waits cover the 2..3 cycle crossing with margin
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	// Both ports shift at once; only the strobe moves a word to the output
	task automatic t_strobe;
		fork
			u_h0.send(16'h1234, 16);
			u_h1.send(16'hA5C3, 16);
		join
		wt(8);
		`CHK("code0 early", 16'h0000, code0)
		`CHK("code1 early", 16'h0000, code1)
		ld0_b = 1'b0;
		wt(3);
		`CHK("upd0 pulse", 1'b1, upd0)
		`CHK("upd1 quiet", 1'b0, upd1)
		wt(2);
		`CHK("upd0 ended", 1'b0, upd0)
		ld0_b = 1'b1;
		`CHK("code0 load", 16'h1234, code0)
		`CHK("code1 kept", 16'h0000, code1)
		ld1_b = 1'b0;
		wt(5);
		ld1_b = 1'b1;
		`CHK("code1 load", 16'hA5C3, code1)
		$display("test strobe done");
	endtask : t_strobe
	// Tied-low strobes: short frame dropped, extra edges ignored
	task automatic t_auto;
		ld0_b = 1'b0;
		ld1_b = 1'b0;
		wt(6);
		u_h0.send(16'h0F0F, 12);
		wt(8);
		`CHK("code0 short", 16'h1234, code0)
		fork
			u_h0.send(16'h8001, 20);
			u_h1.send(16'h7FFE, 16);
		join
		wt(8);
		`CHK("code0 auto", 16'h8001, code0)
		`CHK("code1 auto", 16'h7FFE, code1)
		`CHK("code0 sign", 1'b1, code0 < 0)
		$display("test auto done");
	endtask : t_auto
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		wt(8);
		rst_b = 1'b1;
		wt(3);
		t_strobe();
		t_auto();
		give_verdict();
	end
endmodule : dsdlp_top_tb
